// File: design/pin_sync.sv
// Three-stage pin synchroniser with an agreement filter per bit.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] pinIn, // Raw pin levels.
  output logic [WIDTH-1:0] pinOut // Filtered levels.
);
  // Each bit takes a new level only when the second and third stages agree.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [2:0] stageQ;
    logic filtQ;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        stageQ <= 3'h0;
        filtQ <= 1'b0;
      end else begin
        stageQ <= {stageQ[1:0], pinIn[i]};
        if (stageQ[1] == stageQ[2]) begin
          filtQ <= stageQ[2];
        end
      end
    end
    assign pinOut[i] = filtQ;
  end
endmodule
`default_nettype wire

// File: design/sample_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] inData, // Word to store.
  input wire logic inValid, // Source offers a word.
  output logic inReady, // Room for a word.
  output logic [WIDTH-1:0] outData, // Oldest word.
  output logic outValid, // A word is held.
  input wire logic outReady // Sink takes the oldest word.
);
  // Depth must be a power of two; the extra pointer bit tells full from empty.
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrQ;
  logic [AW:0] rdQ;
  wire logic full = (wrQ[AW] != rdQ[AW]) && (wrQ[AW-1:0] == rdQ[AW-1:0]);
  wire logic empty = (wrQ == rdQ);
  wire logic push = inValid && !full;
  wire logic pop = outReady && !empty;

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdQ[AW-1:0]];

  // Storage carries data only, so it needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrQ[AW-1:0]] <= inData;
    end
  end

  // Pointers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrQ <= '0;
      rdQ <= '0;
    end else begin
      if (push) begin
        wrQ <= wrQ + 1'b1;
      end
      if (pop) begin
        rdQ <= rdQ + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/vbp_consts.svh
// Constants for the voiceband port control-word logic.
`ifndef VBP_CONSTS_SVH
`define VBP_CONSTS_SVH

// Serial word shape.
`define WORD_BITS 16
`define WORD_MSB 15

// Configuration register field positions and reset value.
`define CFG_PREAMP 0
`define CFG_INPUT_SEL 1
`define CFG_DAC_HPF_BYP 2
`define CFG_ADC_HPF_BYP 3
`define CFG_ANALOG_ON 4
`define CFG_DIGITAL_ON 5
`define CFG_GAIN_LSB 7
`define CFG_GAIN_MSB 9
`define CFG_RESET 16'h0000

// Read handshake words.
`define RD_REQ_WORD 16'h8000
`define RD_RDY_WORD 16'hc000

// Bit clock: master clock divided by five, high two phases, low three.
`define BIT_DIV 5
`define BIT_LAST_PHASE 3'h4
`define BIT_HIGH_PHASES 3'h2
`define RX_SAMPLE_PHASE 3'h2

// Frame timing: 125 us frames at a 250 MHz clock.
`define FRAME_PERIOD_NS 125000
`define CLK_FREQ_MHZ 250
`define FRAME_CLKS (`FRAME_PERIOD_NS * `CLK_FREQ_MHZ / 1000)
`define STARTUP_BITS 64

// Sample buffer depth.
`define FIFO_DEPTH 4

`endif

// File: design/vbp_pkg.sv
// Types shared by the voiceband port control-word logic.
`default_nettype none
package vbp_pkg;
  typedef enum logic [0:0] {RX_IDLE, RX_BITS} rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SHIFT} tx_state_e;
endpackage
`default_nettype wire

// File: design/voiceband_port_control_word_logic.sv
// Serial port control-word logic of a voiceband converter.
// Functional notes
// - Config bit 0 set inserts the +20 dB preamplifier, clear bypasses it.
// - Config bit 1 set selects the auxiliary input, clear the primary input.
// - Config bit 2 clear keeps the DAC high-pass filter, set bypasses it.
// - Config bit 3 clear keeps the ADC high-pass filter, set bypasses it.
// - Config bit 4 clear powers the analog section down, set runs it.
// - Config bit 5 clear powers the digital section down, set runs it.
// - Bits 7 to 9 give output gain, +6 dB at 000 down 3 dB per code.
// - Reset clears the whole configuration register to zero.
// - Read request is 0x8000 exactly; read ready is 0xc000 exactly.
// - A control word with MSB high leaves the register untouched; only 0x8000 requests a read.
// - After a request, finish any transfer in progress, then await ready.
// - On the ready word, send the register contents over serial output.
// - Right after readback, resume sample words at the 8 kHz rate.
// - Samples start only after a power-up write and a start-up delay.
// - A control word with MSB low is copied whole into the register.
// - Words are 16 bits MSB first; bit clock is master clock over five.
// - Input sync lasts one bit; 16 bits follow, sampled on falling edges.
// - Output sync pulses at 8 kHz; the word starts one bit after it.
`timescale 1ns/1ps
`default_nettype none
`include "vbp_consts.svh"
module voiceband_port_control_word_logic #(
  parameter int FRAME_CLKS = `FRAME_CLKS,
  parameter int STARTUP_BITS = `STARTUP_BITS
) (
  input wire logic clk, // Master clock, 250 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic serialIn, // Serial data from the host.
  input wire logic inFrameSync, // Input frame sync from the host.
  input wire logic wordTypeSelect, // High for sample, low for control.
  output logic bitClkOut, // Bit clock, master clock over five.
  output logic serialOut, // Serial data to the host.
  output logic outFrameSync, // Output frame sync.
  output logic preampInsert, // Preamplifier inserted.
  output logic inputSourceSelect, // Auxiliary input selected.
  output logic dacHighpassBypass, // DAC high-pass filter bypassed.
  output logic adcHighpassBypass, // ADC high-pass filter bypassed.
  output logic analogPowerOn, // Analog section running.
  output logic digitalPowerOn, // Digital section running.
  output logic [2:0] outputGainCode, // Output gain code.
  input wire logic [15:0] adcData, // Sample word to send.
  input wire logic adcValid, // Sample word offered.
  output logic adcReady, // Sample buffer has room.
  output logic [15:0] dacData, // Last received sample word.
  output logic dacStrobe // One-cycle pulse on a new sample word.
);
  localparam int FRAME_BITS = FRAME_CLKS / `BIT_DIV;
  localparam logic [15:0] FRAME_LAST = 16'(FRAME_BITS - 1);
  localparam logic [15:0] START_LAST = 16'(STARTUP_BITS - 1);

  logic [2:0] phaseQ;
  logic [2:0] phaseD;
  logic bitClkQ;
  logic [2:0] pinsF;
  vbp_pkg::rx_state_e rxStateQ;
  logic [3:0] rxCntQ;
  logic [15:0] rxShiftQ;
  logic rxTypeQ;
  logic [15:0] cfgQ;
  logic [15:0] dacDataQ;
  logic dacStrobeQ;
  logic readPendQ;
  logic readGoQ;
  logic [15:0] startCntQ;
  logic streamingQ;
  logic [15:0] frameCntQ;
  vbp_pkg::tx_state_e txStateQ;
  logic [3:0] txCntQ;
  logic [15:0] txShiftQ;
  logic txIsReadQ;
  logic serialOutQ;
  logic frameSyncQ;
  logic [15:0] lastSampleQ;
  logic [15:0] fifoData;
  logic fifoValid;

  // Host pins are asynchronous to us in principle, so they are filtered.
  pin_sync #(
    .WIDTH(3)
  ) u_pins (
    .clk(clk),
    .nrst(nrst),
    .pinIn({wordTypeSelect, inFrameSync, serialIn}),
    .pinOut(pinsF)
  );
  wire logic sinF = pinsF[0];
  wire logic fsF = pinsF[1];
  wire logic wtsF = pinsF[2];

  // Bit clock phases: high in phases 0 and 1, low in phases 2 to 4.
  wire logic bitTick = (phaseQ == `BIT_LAST_PHASE);
  assign phaseD = bitTick ? 3'h0 : phaseQ + 3'h1;
  // The synchroniser delay is about one phase group, so sampling the
  // filtered pins at phase 2 lands safely inside each host bit.
  wire logic rxStrobe = (phaseQ == `RX_SAMPLE_PHASE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phaseQ <= 3'h2;
      bitClkQ <= 1'b0;
    end else begin
      phaseQ <= phaseD;
      bitClkQ <= (phaseD < `BIT_HIGH_PHASES);
    end
  end

  // Receive decode: the completed word includes the bit sampled now.
  // word decode
  wire logic rxLast = (rxStateQ == vbp_pkg::RX_BITS) && (rxCntQ == 4'hf);
  wire logic rxDone = rxStrobe && rxLast;
  wire logic [15:0] rxWordFull = {rxShiftQ[14:0], sinF};
  wire logic ctrlDone = rxDone && !rxTypeQ;
  wire logic cfgWrite = ctrlDone && !rxWordFull[`WORD_MSB];
  wire logic readReqIn = ctrlDone && (rxWordFull == `RD_REQ_WORD);
  wire logic readRdyIn = ctrlDone && (rxWordFull == `RD_RDY_WORD);

  // input word capture
  // A sync seen in the LSB slot starts the next word straight away; any
  // earlier sync inside a word is ignored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxStateQ <= vbp_pkg::RX_IDLE;
      rxCntQ <= 4'h0;
      rxShiftQ <= 16'h0000;
      rxTypeQ <= 1'b0;
    end else if (rxStrobe) begin
      unique case (rxStateQ)
        vbp_pkg::RX_IDLE: begin
          if (fsF) begin
            rxStateQ <= vbp_pkg::RX_BITS;
            rxCntQ <= 4'h0;
            rxTypeQ <= wtsF;
          end
        end
        vbp_pkg::RX_BITS: begin
          rxShiftQ <= rxWordFull;
          rxCntQ <= rxCntQ + 4'h1;
          if (rxLast) begin
            if (fsF) begin
              rxTypeQ <= wtsF;
            end else begin
              rxStateQ <= vbp_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // register write
  // Reserved bits are stored as written; the host keeps them zero.
  // requests skip the write, since cfgWrite needs the MSB low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgQ <= `CFG_RESET;
    end else if (cfgWrite) begin
      cfgQ <= rxWordFull;
    end
  end

  assign preampInsert = cfgQ[`CFG_PREAMP];
  assign inputSourceSelect = cfgQ[`CFG_INPUT_SEL];
  assign dacHighpassBypass = cfgQ[`CFG_DAC_HPF_BYP];
  assign adcHighpassBypass = cfgQ[`CFG_ADC_HPF_BYP];
  assign analogPowerOn = cfgQ[`CFG_ANALOG_ON];
  assign digitalPowerOn = cfgQ[`CFG_DIGITAL_ON];
  assign outputGainCode = cfgQ[`CFG_GAIN_MSB:`CFG_GAIN_LSB];

  // Received sample words go straight out with a strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dacDataQ <= 16'h0000;
      dacStrobeQ <= 1'b0;
    end else begin
      dacStrobeQ <= rxDone && rxTypeQ;
      if (rxDone && rxTypeQ) begin
        dacDataQ <= rxWordFull;
      end
    end
  end
  assign dacData = dacDataQ;
  assign dacStrobe = dacStrobeQ;

  // Transmit start conditions.
  wire logic txIdle = (txStateQ == vbp_pkg::TX_IDLE);
  wire logic frameTick = (frameCntQ == FRAME_LAST);
  wire logic readStart = bitTick && txIdle && readGoQ;
  wire logic sampleStart = bitTick && txIdle && !readGoQ && !readPendQ
    && streamingQ && frameTick;
  wire logic txLastBit = (txStateQ == vbp_pkg::TX_SHIFT) && (txCntQ == 4'hf);
  wire logic readDone = bitTick && txLastBit && txIsReadQ;
  wire logic powerOn = cfgQ[`CFG_ANALOG_ON] && cfgQ[`CFG_DIGITAL_ON];
  wire logic [15:0] sampleWord = fifoValid ? fifoData : lastSampleQ;
  wire logic [15:0] txWord = readStart ? cfgQ : sampleWord;

  // read handshake state
  // A new request in the cycle the readback starts wins over the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readPendQ <= 1'b0;
      readGoQ <= 1'b0;
    end else begin
      readPendQ <= readReqIn || (readPendQ && !readStart);
      readGoQ <= (readRdyIn && readPendQ) || (readGoQ && !readStart);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startCntQ <= 16'h0000;
      streamingQ <= 1'b0;
    end else if (!powerOn) begin
      startCntQ <= 16'h0000;
      streamingQ <= 1'b0;
    end else if (!streamingQ && bitTick) begin
      startCntQ <= startCntQ + 16'h0001;
      streamingQ <= (startCntQ == START_LAST);
    end
  end

  // held at the last count so the first frame follows at once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameCntQ <= FRAME_LAST;
    end else if (!streamingQ || readDone) begin
      frameCntQ <= FRAME_LAST;
    end else if (bitTick) begin
      frameCntQ <= frameTick ? 16'h0000 : frameCntQ + 16'h0001;
    end
  end

  // output word sequencer
  // Sync stands one bit, then 16 bits MSB first; samples and the
  // readback share the framing.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txStateQ <= vbp_pkg::TX_IDLE;
      txCntQ <= 4'h0;
      txShiftQ <= 16'h0000;
      txIsReadQ <= 1'b0;
      serialOutQ <= 1'b0;
      frameSyncQ <= 1'b0;
    end else if (bitTick) begin
      unique case (txStateQ)
        vbp_pkg::TX_IDLE: begin
          if (readStart || sampleStart) begin
            frameSyncQ <= 1'b1;
            txShiftQ <= txWord;
            txIsReadQ <= readStart;
            txStateQ <= vbp_pkg::TX_SYNC;
          end
        end
        vbp_pkg::TX_SYNC: begin
          frameSyncQ <= 1'b0;
          serialOutQ <= txShiftQ[`WORD_MSB];
          txShiftQ <= {txShiftQ[14:0], 1'b0};
          txCntQ <= 4'h0;
          txStateQ <= vbp_pkg::TX_SHIFT;
        end
        vbp_pkg::TX_SHIFT: begin
          if (txLastBit) begin
            txStateQ <= vbp_pkg::TX_IDLE;
          end else begin
            serialOutQ <= txShiftQ[`WORD_MSB];
            txShiftQ <= {txShiftQ[14:0], 1'b0};
            txCntQ <= txCntQ + 4'h1;
          end
        end
      endcase
    end
  end

  // An empty buffer repeats the last sample rather than stalling frames.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastSampleQ <= 16'h0000;
    end else if (sampleStart && fifoValid) begin
      lastSampleQ <= fifoData;
    end
  end

  // Sample buffer drained only once per frame, so it really fills.
  sample_fifo #(
    .WIDTH(`WORD_BITS),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inData(adcData),
    .inValid(adcValid),
    .inReady(adcReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(sampleStart)
  );

  assign bitClkOut = bitClkQ;
  assign serialOut = serialOutQ;
  assign outFrameSync = frameSyncQ;

  // Checks on the running behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_cfg_reset:
    assert property (disable iff (1'b0) $rose(nrst) |-> cfgQ == 16'h0000)
    else $error("Config register not clear after reset.");
  a_cfg_write:
    assert property (cfgWrite |=> cfgQ == $past(rxWordFull))
    else $error("Control word not copied into register.");
  a_cfg_fields:
    assert property (cfgWrite |=> {outputGainCode, digitalPowerOn,
      analogPowerOn, adcHighpassBypass, dacHighpassBypass,
      inputSourceSelect, preampInsert} ==
      {$past(rxWordFull[9:7]), $past(rxWordFull[5:0])})
    else $error("Config fields do not follow the written word.");
  a_read_keep:
    assert property (ctrlDone && rxWordFull[`WORD_MSB] |=> $stable(cfgQ))
    else $error("Read word altered the config register.");
  a_bitclk_div:
    assert property ($rose(bitClkOut) |=> bitClkOut ##1 !bitClkOut[*3]
      ##1 bitClkOut)
    else $error("Bit clock is not master clock over five.");
  a_sync_width:
    assert property ($rose(outFrameSync) |-> outFrameSync[*5]
      ##1 !outFrameSync)
    else $error("Output sync not one bit long.");
  a_word_len:
    assert property ($fell(outFrameSync) |-> ##79
      (txStateQ == vbp_pkg::TX_SHIFT) ##1 (txStateQ == vbp_pkg::TX_IDLE))
    else $error("Output word not sixteen bits long.");
  a_no_frame_pd:
    assert property (!streamingQ && !readGoQ && txIdle |=> !outFrameSync)
    else $error("Frame sent before start-up completed.");
  a_read_hold:
    assert property (readPendQ && !readGoQ && txIdle |=> !outFrameSync)
    else $error("Sample frame sent while awaiting read ready.");
  a_readback:
    assert property (readRdyIn && readPendQ |-> ##[1:100]
      (outFrameSync && txIsReadQ))
    else $error("Readback did not start after read ready.");
  a_resume:
    assert property (readDone && streamingQ && !readReqIn |-> ##[1:10]
      ($rose(outFrameSync) || readPendQ))
    else $error("Sample frames did not resume after readback.");
endmodule
`default_nettype wire

// File: testbench/host_port_model.sv
// Host serial port model: sends words and collects output frames.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic clk, // System clock.
  input wire logic bitClkOut, // Bit clock from the device.
  input wire logic serialOut, // Device serial data.
  input wire logic outFrameSync, // Device frame sync.
  output logic serialIn, // Host serial data.
  output logic inFrameSync, // Host frame sync.
  output logic wordTypeSelect, // High for sample words.
  output logic [15:0] rxWord, // Last word received.
  output logic [15:0] rxCount, // Words received so far.
  output logic linkMiss // Set if no bit clock rise was found.
);
  logic seenSync;
  logic [15:0] rxW;
  int j;
  // Idle levels at time zero.
  initial begin
    serialIn = 1'b0;
    inFrameSync = 1'b0;
    wordTypeSelect = 1'b1;
    rxWord = 16'h0000;
    rxCount = 16'h0000;
    seenSync = 1'b0;
    linkMiss = 1'b0;
  end
  // sync for one bit with type select, launched four clocks after a bit rise.
  task automatic send_word(input logic [15:0] w, input logic isData);
    logic b0;
    int i;
    b0 = bitClkOut;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      if (bitClkOut && !b0) break;
      b0 = bitClkOut;
    end
    // A dead bit clock is flagged so the bench counts it as a mismatch.
    if (i == 12) linkMiss <= 1'b1;
    repeat (4) @(posedge clk);
    inFrameSync <= 1'b1;
    wordTypeSelect <= isData;
    serialIn <= ~w[15];
    // whole word MSB first, each bit held a full bit period.
    for (i = 15; i >= 0; i--) begin
      repeat (5) @(posedge clk);
      inFrameSync <= 1'b0;
      serialIn <= w[i];
    end
    repeat (5) @(posedge clk);
    serialIn <= ~w[0]; // A released line must not show the stale bit.
  endtask
  // one bit after the sync pulse, 16 bits are sampled.
  always begin
    @(posedge clk);
    if (outFrameSync && !seenSync) begin
      repeat (6) @(posedge clk);
      for (j = 15; j >= 0; j--) begin
        rxW[j] = serialOut;
        if (j > 0) repeat (5) @(posedge clk);
      end
      rxWord <= rxW;
      rxCount <= rxCount + 16'h0001;
    end
    seenSync = outFrameSync;
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the voiceband port control-word logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int FRAME = 200;
  logic clk, nrst, serialIn, inFrameSync, wordTypeSelect, linkMiss;
  logic pb = 1'b0, pf = 1'b0;
  logic bitClkOut, serialOut, outFrameSync, preampInsert, inputSourceSelect;
  logic dacHighpassBypass, adcHighpassBypass, analogPowerOn, digitalPowerOn;
  logic [2:0] outputGainCode;
  logic [15:0] adcData, dacData, rxWord, rxCount, cfg, lastTx, w, n;
  logic adcValid, adcReady, dacStrobe;
  logic [31:0] seed;
  logic [15:0] expQ[$];
  int n_errors = 0, num_checks = 0, cyc = 0, bRise = 0, bGap = 0, fRise = 0;
  int fGap = 0, nStrobe = 0, i, k;
  // The clock toggles every half period of 2 ns.
  // master clock source
  initial clk = 1'b0;
  always #2 clk = ~clk;
  voiceband_port_control_word_logic #(.FRAME_CLKS(FRAME), .STARTUP_BITS(4))
      i_dut (.clk(clk), .nrst(nrst), .serialIn(serialIn),
    .inFrameSync(inFrameSync), .wordTypeSelect(wordTypeSelect),
    .bitClkOut(bitClkOut), .serialOut(serialOut),
    .outFrameSync(outFrameSync), .preampInsert(preampInsert),
    .inputSourceSelect(inputSourceSelect),
    .dacHighpassBypass(dacHighpassBypass),
    .adcHighpassBypass(adcHighpassBypass), .analogPowerOn(analogPowerOn),
    .digitalPowerOn(digitalPowerOn), .outputGainCode(outputGainCode),
    .adcData(adcData), .adcValid(adcValid), .adcReady(adcReady),
    .dacData(dacData), .dacStrobe(dacStrobe));
  host_port_model i_host (.clk(clk), .bitClkOut(bitClkOut),
    .serialOut(serialOut), .outFrameSync(outFrameSync),
    .serialIn(serialIn), .inFrameSync(inFrameSync),
    .wordTypeSelect(wordTypeSelect), .rxWord(rxWord), .rxCount(rxCount),
    .linkMiss(linkMiss));
  // Spacing of bit clock and frame sync rises, and strobe count.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pb <= bitClkOut;
    pf <= outFrameSync;
    if (bitClkOut && !pb) begin
      bGap <= cyc - bRise;
      bRise <= cyc;
    end
    if (outFrameSync && !pf) begin
      fGap <= cyc - fRise;
      fRise <= cyc;
    end
    if (dacStrobe) nStrobe <= nStrobe + 1;
  end
  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Compares every configuration output with the modelled register.
  task automatic check_cfg();
    check("preamp", 16'(preampInsert), 16'(cfg[0]));
    check("source", 16'(inputSourceSelect), 16'(cfg[1]));
    check("dac bypass", 16'(dacHighpassBypass), 16'(cfg[2]));
    check("adc bypass", 16'(adcHighpassBypass), 16'(cfg[3]));
    check("analog on", 16'(analogPowerOn), 16'(cfg[4]));
    check("digital on", 16'(digitalPowerOn), 16'(cfg[5]));
    check("gain", 16'(outputGainCode), 16'(cfg[9:7]));
  endtask
  // A bounded wait for the next complete output frame.
  task automatic wait_frame(input int lim);
    logic [15:0] c0;
    int t;
    c0 = rxCount;
    for (t = 0; t < lim && rxCount == c0; t++) @(posedge clk);
    if (rxCount == c0) begin
      check("frame wait", 16'h0001, 16'h0000);
      final_report();
    end
  endtask
  // Main sequence: reset, writes, reads, streaming, a live read, then power-down.
  initial begin
    seed = 32'hec12;
    nrst = 1'b0;
    adcData = 16'h0000;
    adcValid = 1'b0;
    cfg = 16'h0000;
    lastTx = 16'h0000;
    repeat (2) @(posedge clk);
    check_cfg();
    check("ready", 16'(adcReady), 16'h0001);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = {6'h00, i[2:0], 1'b0, ~i[0], i[0], seed[3:0]};
      i_host.send_word(w, 1'b0);
      repeat (20) @(posedge clk);
      cfg = w;
      check_cfg();
    end
    check("early frames", rxCount, 16'h0000);
    $display("test writes done");
    i_host.send_word(16'h8000, 1'b0);
    repeat (20) @(posedge clk);
    check_cfg();
    i_host.send_word(16'hc000, 1'b0);
    wait_frame(200);
    check("readback", rxWord, cfg);
    $display("test idle read done");
    // A ready word with no request pending must not start a readback.
    i_host.send_word(16'hc000, 1'b0);
    n = rxCount;
    repeat (FRAME) @(posedge clk);
    check("stray ready", rxCount, n);
    check_cfg();
    seed = xs(seed);
    adcData <= seed[15:0];
    adcValid <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (adcReady) expQ.push_back(adcData);
      seed = xs(seed);
      adcData <= seed[15:0];
    end
    adcValid <= 1'b0;
    check("fill count", 16'(expQ.size()), 16'h0004);
    w = {6'h00, seed[2:0], 7'h30};
    i_host.send_word(w, 1'b0);
    cfg = w;
    for (i = 0; i < 6; i++) begin
      wait_frame(FRAME + 400);
      if (expQ.size() > 0) lastTx = expQ.pop_front();
      check("sample", rxWord, lastTx);
    end
    check("drained", 16'(adcReady), 16'h0001);
    check("frame gap", 16'(fGap), 16'(FRAME));
    check("bit gap", 16'(bGap), 16'h0005);
    $display("test streaming done");
    seed = xs(seed);
    k = nStrobe;
    i_host.send_word(seed[15:0], 1'b1);
    repeat (20) @(posedge clk);
    check("dac word", dacData, seed[15:0]);
    check("strobes", 16'(nStrobe - k), 16'h0001);
    check_cfg();
    i_host.send_word(16'h8000, 1'b0);
    n = rxCount;
    repeat (FRAME * 2) @(posedge clk);
    check("held frames", 16'(rxCount - n <= 16'h0001), 16'h0001);
    i_host.send_word(16'hc000, 1'b0);
    wait_frame(200);
    check("live readback", rxWord, cfg);
    k = cyc;
    wait_frame(200);
    check("resume soon", 16'(cyc - k < 120), 16'h0001);
    check("resume word", rxWord, lastTx);
    $display("test live read done");
    cfg = 16'h0000;
    i_host.send_word(cfg, 1'b0);
    n = rxCount;
    repeat (FRAME * 3) @(posedge clk);
    check("stopped", 16'(rxCount - n <= 16'h0001), 16'h0001);
    check_cfg();
    $display("test powerdown done");
    check("link miss", 16'(linkMiss), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
